// ---- dac_ctrl_pkg.sv ----
package dac_ctrl_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_GENCFG  = 8'h00;
  localparam logic [7:0] ADDR_OUTCTL  = 8'h04;
  localparam logic [7:0] ADDR_CODE    = 8'h08;
  localparam logic [7:0] ADDR_ADIAG   = 8'h0C;
  localparam logic [7:0] ADDR_IRQSTAT = 8'h10;
  localparam logic [7:0] ADDR_IRQMASK = 8'h14;
  localparam logic [7:0] ADDR_CMD     = 8'h18;
  localparam logic [7:0] ADDR_STATUS  = 8'h1C;

  // general_config_one_reg fields
  localparam int GENCFG_PULLDOWN_BIT = 0;
  localparam int GENCFG_MODEM_BIT    = 1;
  // Output control fields
  localparam int OUTCTL_VOLT_BIT     = 0;
  localparam int OUTCTL_CURR_BIT     = 1;
  localparam int OUTCTL_BIPOLAR_BIT  = 2;
  // analog_diag_flags_reg fields, also irq bits 0 and 1
  localparam int DIAG_VSHORT_BIT     = 0;
  localparam int DIAG_IOPEN_BIT      = 1;
  localparam int IRQ_READY_BIT       = 2;
  localparam int IRQ_CALDONE_BIT     = 3;
  // Command fields
  localparam int CMD_SWRESET_BIT     = 0;
  localparam int CMD_CALREFRESH_BIT  = 1;
  // Status fields
  localparam int STATUS_INRESET_BIT  = 0;
  localparam int STATUS_QUIET_BIT    = 1;
  localparam int STATUS_CALBUSY_BIT  = 2;
  localparam int STATUS_CALDONE_BIT  = 3;

  // Reset values
  localparam logic [1:0]  GENCFG_RESET  = 2'h0;
  localparam logic [2:0]  OUTCTL_RESET  = 3'h0;
  localparam logic [15:0] CODE_RESET    = 16'h0000;
  localparam logic [1:0]  ADIAG_RESET   = 2'h0;
  localparam logic [3:0]  IRQ_RESET     = 4'h0;
  localparam logic [15:0] CODE_MIDSCALE = 16'h8000;

  // Timing
  localparam int CLK_FREQ_HZ     = 10_000_000;
  localparam int QUIET_TIME_US   = 100;
  localparam int CAL_WAIT_US     = 500;
  localparam int QUIET_CYCLES    = QUIET_TIME_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int CAL_WAIT_CYCLES = CAL_WAIT_US * (CLK_FREQ_HZ / 1_000_000);

  typedef enum logic [1:0] {
    ST_HOLD    = 2'b00,
    ST_QUIET   = 2'b01,
    ST_RUN     = 2'b10,
    ST_CALWAIT = 2'b11
  } seq_state_t;

endpackage

// ---- pin_sync3.sv ----
`timescale 1ns/1ps
`default_nettype none

module pin_sync3 #(
  parameter int WIDTH = 6
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] pinIn,
  output var  logic [WIDTH-1:0] pinOut
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
    end else begin
      stage1_reg <= pinIn;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // A bit changes only once the last two stages agree
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pinOut <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2_reg[i] == stage3_reg[i]) begin
          pinOut[i] <= stage3_reg[i];
        end
      end
    end
  end

endmodule // pin_sync3

`default_nettype wire

// ---- dac_reset_and_fault_control.sv ----
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Bipolar range reads the 16-bit code as offset binary, 0x8000 is zero.
// - After any reset both voltage and current outputs stay disabled.
// - Pull-down switch open after reset, closed only by its config bit.
// - Logic held in reset while regulator or analog supply is low.
// - Reset pin and software reset command both reset the device.
// - Voltage-mode short sets voltage_short_flag and pulls alarm low.
// - Current-mode open loop sets current_open_flag and pulls alarm low.
// - Modem input reaches the output only with its enable and output on.
// - Diag flags sticky, write one clears; alarm high when no fault left.
// - Only one of current or voltage output may be enabled.
module dac_reset_and_fault_control #(
  parameter int CAL_WAIT_CYCLES = dac_ctrl_pkg::CAL_WAIT_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        wbCyc,
  input  wire logic        wbStb,
  input  wire logic        wbWe,
  input  wire logic [7:0]  wbAdr,
  input  wire logic [3:0]  wbSel,
  input  wire logic [31:0] wbDatIn,
  output var  logic [31:0] wbDatOut,
  output var  logic        wbAck,
  input  wire logic        resetPin_n,
  input  wire logic        regulatorGood,
  input  wire logic        analogSupplyGood,
  input  wire logic        shortDetect,
  input  wire logic        openDetect,
  input  wire logic        modemCoupleInput,
  output var  logic        voltOutEnable,
  output var  logic        currOutEnable,
  output var  logic        pullDownClose,
  output var  logic        modemCoupleOut,
  output var  logic [15:0] dacLevel,
  output var  logic        alarm_n,
  output var  logic        deviceInReset,
  output var  logic        irq
);

  localparam logic [15:0] QUIET_LAST =
    16'(dac_ctrl_pkg::QUIET_CYCLES - 1);
  localparam logic [15:0] CAL_LAST = 16'(CAL_WAIT_CYCLES - 1);

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] laneMerge(input logic [31:0] oldVal,
                                             input logic [31:0] newVal,
                                             input logic [3:0]  sel);
    logic [31:0] res;
    res = oldVal;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = newVal[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Offset binary to two's complement
  function automatic logic [15:0] offsetToSigned(input logic [15:0] code);
    return code ^ dac_ctrl_pkg::CODE_MIDSCALE;
  endfunction

  logic [5:0] pinSync;
  logic       syncPinN;
  logic       syncRegGood;
  logic       syncAvccGood;
  logic       syncShort;
  logic       syncOpen;
  logic       syncModem;

  pin_sync3 #(
    .WIDTH (6)
  ) u_pin_sync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .pinIn   ({modemCoupleInput, openDetect, shortDetect,
               analogSupplyGood, regulatorGood, resetPin_n}),
    .pinOut  (pinSync)
  );

  assign syncPinN     = pinSync[0];
  assign syncRegGood  = pinSync[1];
  assign syncAvccGood = pinSync[2];
  assign syncShort    = pinSync[3];
  assign syncOpen     = pinSync[4];
  assign syncModem    = pinSync[5];

  dac_ctrl_pkg::seq_state_t stateReg;
  dac_ctrl_pkg::seq_state_t stateNext;
  logic [15:0] seqCntReg;
  logic [15:0] seqCntNext;
  logic        calDoneReg;
  logic        holdSource;
  logic        swResetPulse;
  logic        calCmdPulse;
  logic        clearAll;
  logic        accepting;
  logic        busReq;
  logic        wrAccess;
  logic        rdAccess;
  logic [1:0]  genCfgReg;
  logic [2:0]  outCtlReg;
  logic [15:0] codeReg;
  logic [1:0]  diagReg;
  logic [1:0]  diagNext;
  logic [3:0]  irqStatReg;
  logic [3:0]  irqMaskReg;
  logic [3:0]  irqEvents;
  logic [31:0] rdData;
  logic [31:0] wrMerged;
  logic [31:0] codeMerged;
  logic [31:0] maskMerged;
  logic        setShort;
  logic        setOpen;

  assign busReq   = wbCyc && wbStb && !wbAck;
  assign wrAccess = busReq && wbWe;
  assign rdAccess = busReq && !wbWe;
  assign wrMerged = laneMerge(32'h0000_0000, wbDatIn, wbSel);
  // Slices are taken on nets; a select on a call result is not portable
  assign codeMerged = laneMerge({16'h0000, codeReg}, wbDatIn, wbSel);
  assign maskMerged = laneMerge({28'h0000000, irqMaskReg}, wbDatIn, wbSel);

  assign holdSource = !syncPinN || !syncRegGood || !syncAvccGood;
  assign swResetPulse = wrAccess && (wbAdr == dac_ctrl_pkg::ADDR_CMD) &&
                        wrMerged[dac_ctrl_pkg::CMD_SWRESET_BIT] && accepting;
  assign calCmdPulse = wrAccess && (wbAdr == dac_ctrl_pkg::ADDR_CMD) &&
                       wrMerged[dac_ctrl_pkg::CMD_CALREFRESH_BIT] &&
                       accepting && !swResetPulse;
  // every reset source clears device state
  assign clearAll = reset || (stateReg == dac_ctrl_pkg::ST_HOLD);
  // commands only outside hold and quiet window
  assign accepting = (stateReg == dac_ctrl_pkg::ST_RUN) ||
                     (stateReg == dac_ctrl_pkg::ST_CALWAIT);

  // Reset sequencer
  always_comb begin
    stateNext  = stateReg;
    seqCntNext = seqCntReg;
    case (stateReg)
      dac_ctrl_pkg::ST_HOLD: begin
        seqCntNext = 16'h0000;
        if (!holdSource) begin
          stateNext = dac_ctrl_pkg::ST_QUIET;
        end
      end
      dac_ctrl_pkg::ST_QUIET: begin
        // quiet window after a reset event
        seqCntNext = seqCntReg + 16'h0001;
        if (seqCntReg == QUIET_LAST) begin
          stateNext  = dac_ctrl_pkg::ST_RUN;
          seqCntNext = 16'h0000;
        end
      end
      dac_ctrl_pkg::ST_RUN: begin
        seqCntNext = 16'h0000;
        if (calCmdPulse) begin
          stateNext = dac_ctrl_pkg::ST_CALWAIT;
        end
      end
      dac_ctrl_pkg::ST_CALWAIT: begin
        seqCntNext = seqCntReg + 16'h0001;
        if (calCmdPulse) begin
          seqCntNext = 16'h0000;
        end else if (seqCntReg == CAL_LAST) begin
          stateNext  = dac_ctrl_pkg::ST_RUN;
          seqCntNext = 16'h0000;
        end
      end
      default: begin
        stateNext  = dac_ctrl_pkg::ST_HOLD;
        seqCntNext = 16'h0000;
      end
    endcase
    if (holdSource || swResetPulse) begin
      stateNext  = dac_ctrl_pkg::ST_HOLD;
      seqCntNext = 16'h0000;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stateReg  <= dac_ctrl_pkg::ST_HOLD;
      seqCntReg <= 16'h0000;
    end else begin
      stateReg  <= stateNext;
      seqCntReg <= seqCntNext;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clearAll) begin
      calDoneReg <= 1'b0;
    end else if (stateReg == dac_ctrl_pkg::ST_CALWAIT &&
                 stateNext == dac_ctrl_pkg::ST_RUN) begin
      calDoneReg <= 1'b1;
    end
  end

  // Configuration registers
  always_ff @(posedge clk_sys) begin
    // switch open and config cleared on reset
    if (clearAll) begin
      genCfgReg <= dac_ctrl_pkg::GENCFG_RESET;
    end else if (wrAccess && accepting &&
                 wbAdr == dac_ctrl_pkg::ADDR_GENCFG) begin
      genCfgReg <= wrMerged[1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clearAll) begin
      outCtlReg <= dac_ctrl_pkg::OUTCTL_RESET;
    end else if (wrAccess && accepting &&
                 wbAdr == dac_ctrl_pkg::ADDR_OUTCTL && wbSel[0]) begin
      outCtlReg[dac_ctrl_pkg::OUTCTL_BIPOLAR_BIT] <=
        wbDatIn[dac_ctrl_pkg::OUTCTL_BIPOLAR_BIT];
      // both enables at once is refused
      if (!(wbDatIn[dac_ctrl_pkg::OUTCTL_VOLT_BIT] &&
            wbDatIn[dac_ctrl_pkg::OUTCTL_CURR_BIT])) begin
        outCtlReg[1:0] <= wbDatIn[1:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clearAll) begin
      codeReg <= dac_ctrl_pkg::CODE_RESET;
    end else if (wrAccess && accepting &&
                 wbAdr == dac_ctrl_pkg::ADDR_CODE) begin
      codeReg <= codeMerged[15:0];
    end
  end

  assign setShort = syncShort && outCtlReg[dac_ctrl_pkg::OUTCTL_VOLT_BIT];
  assign setOpen  = syncOpen && outCtlReg[dac_ctrl_pkg::OUTCTL_CURR_BIT];

  always_comb begin
    diagNext = diagReg;
    // write one clears that bit alone
    if (wrAccess && accepting && wbAdr == dac_ctrl_pkg::ADDR_ADIAG &&
        wbSel[0]) begin
      diagNext = diagReg & ~wbDatIn[1:0];
    end
    // Set wins over a clear in the same cycle
    if (setShort) begin
      diagNext[dac_ctrl_pkg::DIAG_VSHORT_BIT] = 1'b1;
    end
    if (setOpen) begin
      diagNext[dac_ctrl_pkg::DIAG_IOPEN_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    // flags cleared on every reset source
    if (clearAll) begin
      diagReg <= dac_ctrl_pkg::ADIAG_RESET;
      alarm_n <= 1'b1;
    end else begin
      diagReg <= diagNext;
      // alarm released only with no fault left
      alarm_n <= !((|diagNext) || setShort || setOpen);
    end
  end

  // Outputs toward the analog side
  always_ff @(posedge clk_sys) begin
    if (clearAll) begin
      voltOutEnable  <= 1'b0;
      currOutEnable  <= 1'b0;
      pullDownClose  <= 1'b0;
      modemCoupleOut <= 1'b0;
      dacLevel       <= 16'h0000;
    end else begin
      voltOutEnable <= outCtlReg[dac_ctrl_pkg::OUTCTL_VOLT_BIT];
      currOutEnable <= outCtlReg[dac_ctrl_pkg::OUTCTL_CURR_BIT];
      pullDownClose <= genCfgReg[dac_ctrl_pkg::GENCFG_PULLDOWN_BIT];
      // modem coupling gated by enable and output
      modemCoupleOut <= syncModem &&
                        genCfgReg[dac_ctrl_pkg::GENCFG_MODEM_BIT] &&
                        outCtlReg[dac_ctrl_pkg::OUTCTL_CURR_BIT];
      dacLevel <= outCtlReg[dac_ctrl_pkg::OUTCTL_BIPOLAR_BIT] ?
                  offsetToSigned(codeReg) : codeReg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      deviceInReset <= 1'b1;
    end else begin
      deviceInReset <= (stateNext == dac_ctrl_pkg::ST_HOLD);
    end
  end

  // Interrupts: events only on a new flag or sequencer milestone
  assign irqEvents = {
    calDoneReg == 1'b0 && stateReg == dac_ctrl_pkg::ST_CALWAIT &&
      stateNext == dac_ctrl_pkg::ST_RUN,
    stateReg == dac_ctrl_pkg::ST_QUIET && stateNext == dac_ctrl_pkg::ST_RUN,
    setOpen && !diagReg[dac_ctrl_pkg::DIAG_IOPEN_BIT],
    setShort && !diagReg[dac_ctrl_pkg::DIAG_VSHORT_BIT]
  };

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irqStatReg <= dac_ctrl_pkg::IRQ_RESET;
    end else if (rdAccess && wbAdr == dac_ctrl_pkg::ADDR_IRQSTAT) begin
      // Read clears, but an event in the same cycle survives
      irqStatReg <= irqEvents;
    end else begin
      irqStatReg <= irqStatReg | irqEvents;
    end
  end

  // Mask lives on the bus side so it survives device resets
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irqMaskReg <= dac_ctrl_pkg::IRQ_RESET;
    end else if (wrAccess && wbAdr == dac_ctrl_pkg::ADDR_IRQMASK) begin
      irqMaskReg <= maskMerged[3:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatReg & irqMaskReg);
    end
  end

  // Register read mux
  always_comb begin
    rdData = 32'h0000_0000;
    case (wbAdr)
      dac_ctrl_pkg::ADDR_GENCFG:  rdData[1:0]  = genCfgReg;
      dac_ctrl_pkg::ADDR_OUTCTL:  rdData[2:0]  = outCtlReg;
      dac_ctrl_pkg::ADDR_CODE:    rdData[15:0] = codeReg;
      dac_ctrl_pkg::ADDR_ADIAG:   rdData[1:0]  = diagReg;
      dac_ctrl_pkg::ADDR_IRQSTAT: rdData[3:0]  = irqStatReg;
      dac_ctrl_pkg::ADDR_IRQMASK: rdData[3:0]  = irqMaskReg;
      dac_ctrl_pkg::ADDR_STATUS: begin
        rdData[dac_ctrl_pkg::STATUS_INRESET_BIT] =
          (stateReg == dac_ctrl_pkg::ST_HOLD);
        rdData[dac_ctrl_pkg::STATUS_QUIET_BIT] =
          (stateReg == dac_ctrl_pkg::ST_QUIET);
        rdData[dac_ctrl_pkg::STATUS_CALBUSY_BIT] =
          (stateReg == dac_ctrl_pkg::ST_CALWAIT);
        rdData[dac_ctrl_pkg::STATUS_CALDONE_BIT] = calDoneReg;
      end
      default: rdData = 32'h0000_0000;
    endcase
  end

  // Classic Wishbone: one wait state, ack for one cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wbAck    <= 1'b0;
      wbDatOut <= 32'h0000_0000;
    end else begin
      wbAck <= busReq;
      if (rdAccess) begin
        wbDatOut <= rdData;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  property p_modeExcl;
    !(voltOutEnable && currOutEnable);
  endproperty
  a_modeExcl: assert property (p_modeExcl)
    else $error("both output modes enabled");

  property p_holdClears;
    (stateReg == dac_ctrl_pkg::ST_HOLD) |=> ##1
      (!voltOutEnable && !currOutEnable && diagReg == 2'h0);
  endproperty
  a_holdClears: assert property (p_holdClears)
    else $error("outputs or flags survive reset");

  property p_pullOpen;
    (stateReg == dac_ctrl_pkg::ST_HOLD) |=> ##1 !pullDownClose;
  endproperty
  a_pullOpen: assert property (p_pullOpen)
    else $error("pull-down closed after reset");

  property p_supplyHold;
    (!syncRegGood || !syncAvccGood) |=> (stateReg == dac_ctrl_pkg::ST_HOLD);
  endproperty
  a_supplyHold: assert property (p_supplyHold)
    else $error("logic not held with supply low");

  property p_shortFlag;
    (setShort && !clearAll) |=>
      (diagReg[dac_ctrl_pkg::DIAG_VSHORT_BIT] && !alarm_n);
  endproperty
  a_shortFlag: assert property (p_shortFlag)
    else $error("short not flagged");

  property p_openFlag;
    (setOpen && !clearAll) |=>
      (diagReg[dac_ctrl_pkg::DIAG_IOPEN_BIT] && !alarm_n);
  endproperty
  a_openFlag: assert property (p_openFlag)
    else $error("open loop not flagged");

  property p_modemGate;
    modemCoupleOut |-> $past(genCfgReg[dac_ctrl_pkg::GENCFG_MODEM_BIT]) &&
                       $past(outCtlReg[dac_ctrl_pkg::OUTCTL_CURR_BIT]);
  endproperty
  a_modemGate: assert property (p_modemGate)
    else $error("modem coupled without enables");

  property p_alarmRelease;
    (diagReg == 2'h0 && !setShort && !setOpen) ##1
      (diagReg == 2'h0 && !setShort && !setOpen) |-> alarm_n;
  endproperty
  a_alarmRelease: assert property (p_alarmRelease)
    else $error("alarm low with no fault");

  property p_ignoreHold;
    (wrAccess && stateReg != dac_ctrl_pkg::ST_RUN &&
     stateReg != dac_ctrl_pkg::ST_CALWAIT) |=> $stable(codeReg) ||
      codeReg == dac_ctrl_pkg::CODE_RESET;
  endproperty
  a_ignoreHold: assert property (p_ignoreHold)
    else $error("command taken during hold");

  property p_midscale;
    (outCtlReg[dac_ctrl_pkg::OUTCTL_BIPOLAR_BIT] &&
     codeReg == dac_ctrl_pkg::CODE_MIDSCALE && !clearAll) |=>
      dacLevel == 16'h0000;
  endproperty
  a_midscale: assert property (p_midscale)
    else $error("midscale code not zero");

  property p_ackPulse;
    wbAck |=> !wbAck;
  endproperty
  a_ackPulse: assert property (p_ackPulse)
    else $error("ack longer than one cycle");

  c_quietDone: cover property (stateReg == dac_ctrl_pkg::ST_QUIET ##1
                               stateReg == dac_ctrl_pkg::ST_RUN);
  c_calDone: cover property ($rose(calDoneReg));
  c_alarm: cover property ($fell(alarm_n));
  c_irq: cover property ($rose(irq));

endmodule // dac_reset_and_fault_control

`default_nettype wire

// ---- front_end_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module front_end_model (
  input  wire logic clk_sys,
  input  wire logic supplyOn,
  input  wire logic pinReset,
  input  wire logic shortOn,
  input  wire logic openOn,
  input  wire logic modemLevel,
  output var  logic resetPin_n,
  output var  logic regulatorGood,
  output var  logic analogSupplyGood,
  output var  logic shortDetect,
  output var  logic openDetect,
  output var  logic modemCoupleInput
);
  initial begin
    resetPin_n = 1'b0;
    regulatorGood = 1'b0;
    analogSupplyGood = 1'b0;
    shortDetect = 1'b0;
    openDetect = 1'b0;
    modemCoupleInput = 1'b0;
  end
  // Both rails move together; a split rail is not modelled
  always @(posedge clk_sys) begin
    regulatorGood <= supplyOn;
    analogSupplyGood <= supplyOn;
    resetPin_n <= ~pinReset;
  end
  always @(posedge clk_sys) begin
    shortDetect <= shortOn;
    openDetect <= openOn;
    modemCoupleInput <= modemLevel;
  end
endmodule // front_end_model

`default_nettype wire

// ---- dac_reset_and_fault_control_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module dac_reset_and_fault_control_tb_top;
  localparam int CAL_CYC = 20;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        wbCyc = 1'b0;
  logic        wbStb = 1'b0;
  logic        wbWe = 1'b0;
  logic [7:0]  wbAdr = 8'h00;
  logic [3:0]  wbSel = 4'hF;
  logic [31:0] wbDatIn = 32'h00000000;
  logic [31:0] wbDatOut;
  logic        wbAck;
  logic        supplyOn = 1'b0;
  logic        pinReset = 1'b0;
  logic        shortOn = 1'b0;
  logic        openOn = 1'b0;
  logic        modemLevel = 1'b0;
  logic        resetPin_n, regulatorGood, analogSupplyGood;
  logic        shortDetect, openDetect, modemCoupleInput;
  logic        voltOutEnable, currOutEnable, pullDownClose;
  logic        modemCoupleOut, alarm_n, deviceInReset, irq;
  logic [15:0] dacLevel;
  logic [31:0] q;
  logic [15:0] codes [4] = '{16'h8000, 16'hFFFF, 16'h0001, 16'h0000};
  int          failures = 0;
  int          comparisons = 0;

  always #50 clk_sys = ~clk_sys;

  dac_reset_and_fault_control #(.CAL_WAIT_CYCLES(CAL_CYC)) dut (
    .clk_sys(clk_sys), .reset(reset), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn),
    .wbDatOut(wbDatOut), .wbAck(wbAck), .resetPin_n(resetPin_n),
    .regulatorGood(regulatorGood), .analogSupplyGood(analogSupplyGood),
    .shortDetect(shortDetect), .openDetect(openDetect),
    .modemCoupleInput(modemCoupleInput), .voltOutEnable(voltOutEnable),
    .currOutEnable(currOutEnable), .pullDownClose(pullDownClose),
    .modemCoupleOut(modemCoupleOut), .dacLevel(dacLevel),
    .alarm_n(alarm_n), .deviceInReset(deviceInReset), .irq(irq)
  );

  front_end_model model (
    .clk_sys(clk_sys), .supplyOn(supplyOn), .pinReset(pinReset),
    .shortOn(shortOn), .openOn(openOn), .modemLevel(modemLevel),
    .resetPin_n(resetPin_n), .regulatorGood(regulatorGood),
    .analogSupplyGood(analogSupplyGood), .shortDetect(shortDetect),
    .openDetect(openDetect), .modemCoupleInput(modemCoupleInput)
  );

  task automatic print_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Held until ack; the next call starts an edge later, so one idle cycle
  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [31:0] dat, output logic [31:0] rdat);
    int n;
    n = 0;
    @(posedge clk_sys);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatIn <= dat;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    rdat = wbDatOut;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    if (n >= 50) failures++;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] d;
    wb(1'b1, adr, dat, d);
  endtask

  task automatic rd(input string nm, input logic [7:0] adr,
                    input logic [31:0] exp);
    logic [31:0] d;
    wb(1'b0, adr, 32'h00000000, d);
    chk(nm, d, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Quiet time is 1000 cycles; the poll bound allows well over that
  task automatic waitRun;
    logic [31:0] d;
    int n;
    n = 0;
    do begin
      wb(1'b0, dac_ctrl_pkg::ADDR_STATUS, 32'h00000000, d);
      n++;
    end while (d[1:0] !== 2'b00 && n < 600);
    if (n >= 600) failures++;
  endtask

  initial begin
    idle(20);
    reset <= 1'b0;
    idle(10);
    chk("inReset", 32'(deviceInReset), 32'h1);
    chk("voltEn", 32'(voltOutEnable), 32'h0);
    chk("currEn", 32'(currOutEnable), 32'h0);
    chk("pullDown", 32'(pullDownClose), 32'h0);
    chk("alarm", 32'(alarm_n), 32'h1);
    // supply up, then check that a write during the quiet time is ignored
    supplyOn <= 1'b1;
    idle(10);
    rd("status", dac_ctrl_pkg::ADDR_STATUS, 32'h2);
    wr(dac_ctrl_pkg::ADDR_GENCFG, 32'h1);
    rd("gencfg", dac_ctrl_pkg::ADDR_GENCFG, 32'h0);
    waitRun;
    // refresh first, then wait out the calibration
    wr(dac_ctrl_pkg::ADDR_CMD, 32'h2);
    rd("calBusy", dac_ctrl_pkg::ADDR_STATUS, 32'h4);
    idle(CAL_CYC + 5);
    rd("calDone", dac_ctrl_pkg::ADDR_STATUS, 32'h8);
    wr(dac_ctrl_pkg::ADDR_OUTCTL, 32'h3);
    idle(2);
    chk("bothEn", {30'h0, voltOutEnable, currOutEnable}, 32'h0);
    wr(dac_ctrl_pkg::ADDR_OUTCTL, 32'h5);
    for (int i = 0; i < 4; i++) begin
      wr(dac_ctrl_pkg::ADDR_CODE, {16'h0000, codes[i]});
      idle(2);
      chk("level", 32'(dacLevel), {16'h0, ~codes[i][15], codes[i][14:0]});
    end
    shortOn <= 1'b1;
    idle(8);
    chk("alarmShort", 32'(alarm_n), 32'h0);
    rd("diagShort", dac_ctrl_pkg::ADDR_ADIAG, 32'h1);
    shortOn <= 1'b0;
    idle(8);
    chk("alarmSticky", 32'(alarm_n), 32'h0);
    wr(dac_ctrl_pkg::ADDR_IRQMASK, 32'h1);
    idle(2);
    chk("irqOn", 32'(irq), 32'h1);
    wr(dac_ctrl_pkg::ADDR_IRQMASK, 32'h0);
    idle(2);
    chk("irqMasked", 32'(irq), 32'h0);
    wr(dac_ctrl_pkg::ADDR_IRQMASK, 32'h1);
    rd("irqStat", dac_ctrl_pkg::ADDR_IRQSTAT, 32'hD);
    idle(2);
    chk("irqCleared", 32'(irq), 32'h0);
    rd("unmapped", 8'h40, 32'h0);
    wr(dac_ctrl_pkg::ADDR_ADIAG, 32'h1);
    idle(2);
    rd("diagClr", dac_ctrl_pkg::ADDR_ADIAG, 32'h0);
    chk("alarmClr", 32'(alarm_n), 32'h1);
    wr(dac_ctrl_pkg::ADDR_OUTCTL, 32'h2);
    idle(2);
    chk("modeSwap", {30'h0, voltOutEnable, currOutEnable}, 32'h1);
    openOn <= 1'b1;
    idle(8);
    chk("alarmOpen", 32'(alarm_n), 32'h0);
    rd("diagOpen", dac_ctrl_pkg::ADDR_ADIAG, 32'h2);
    openOn <= 1'b0;
    modemLevel <= 1'b1;
    wr(dac_ctrl_pkg::ADDR_ADIAG, 32'h1);
    idle(8);
    chk("alarmOther", 32'(alarm_n), 32'h0);
    rd("diagOther", dac_ctrl_pkg::ADDR_ADIAG, 32'h2);
    wr(dac_ctrl_pkg::ADDR_GENCFG, 32'h1);
    idle(8);
    chk("pullDownOn", 32'(pullDownClose), 32'h1);
    chk("modemOff", 32'(modemCoupleOut), 32'h0);
    wr(dac_ctrl_pkg::ADDR_GENCFG, 32'h3);
    idle(8);
    chk("modemOn", 32'(modemCoupleOut), 32'h1);
    wr(dac_ctrl_pkg::ADDR_CMD, 32'h1);
    idle(4);
    wb(1'b0, dac_ctrl_pkg::ADDR_STATUS, 32'h0, q);
    chk("swReset", {30'h0, q[1:0]}, 32'h2);
    chk("pullDownRst", 32'(pullDownClose), 32'h0);
    chk("currRst", 32'(currOutEnable), 32'h0);
    chk("modemRst", 32'(modemCoupleOut), 32'h0);
    rd("diagRst", dac_ctrl_pkg::ADDR_ADIAG, 32'h0);
    wr(dac_ctrl_pkg::ADDR_GENCFG, 32'h1);
    rd("gencfgQuiet", dac_ctrl_pkg::ADDR_GENCFG, 32'h0);
    waitRun;
    pinReset <= 1'b1;
    idle(10);
    chk("pinReset", 32'(deviceInReset), 32'h1);
    pinReset <= 1'b0;
    waitRun;
    supplyOn <= 1'b0;
    idle(10);
    chk("supplyLow", 32'(deviceInReset), 32'h1);
    supplyOn <= 1'b1;
    waitRun;
    print_verdict;
  end

  // Whole run is near 4240 cycles; a hang is cut at 20000
  initial begin
    idle(20000);
    failures++;
    print_verdict;
  end
endmodule // dac_reset_and_fault_control_tb_top

`default_nettype wire
